// File: hw/tcu_top.sv
// Transfer checksum unit: XOR or CRC-8 over data writes
// How it works
// - Checksum over memory data writes, XOR or CRC-8 result.
// - One select bit chooses XOR or CRC-8, written by the host.
// - Select 0: each written byte XORs into the checksum.
// - Select 1: CRC-8 step, polynomial x^8+x^5+x^4+1.
// - Checksum clears when register select or direction bits change.
// - Host reads the current checksum via status readback.
`include "tcu_defines.svh"
`default_nettype none
module tcu_top (
    // Core clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Link clock domain, bus decoder side
    input wire logic link_clk_in,
    input wire logic link_rst_n_in,
    input wire logic data_write_in,
    input wire logic [7:0] data_byte_in,
    input wire logic checksum_algorithm_select_in,
    input wire logic [1:0] register_select_bits_in,
    input wire logic read_write_in,
    input wire logic status_read_in,
    // Readback, link domain
    output logic [7:0] readback_data_out,
    output logic readback_valid_out,
    // Core domain view
    output logic [7:0] checksum_out
);
    // Link side capture: a toggle marks each written byte
    logic link_tog;
    tcu_pkg::tcu_byte_t link_byte;
    always_ff @(posedge link_clk_in) begin
        if (!link_rst_n_in) begin
            link_tog <= 1'b0;
        end else if (data_write_in) begin
            link_tog <= ~link_tog;
        end
    end
    // Byte stays put until the next write, so it is settled
    // long before its toggle has crossed
    always_ff @(posedge link_clk_in) begin
        if (!link_rst_n_in) begin
            link_byte <= `TCU_CSUM_RESET;
        end else if (data_write_in) begin
            link_byte <= data_byte_in;
        end
    end

    // Link domain levels into the core domain, two flops each
    logic tog_sync;
    logic alg_sync;
    logic [1:0] rs_sync;
    logic rw_sync;
    tcu_sync #(.WIDTH(1)) u_sync_tog (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .d_in(link_tog),
        .q_out(tog_sync)
    );
    tcu_sync #(.WIDTH(1)) u_sync_alg (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .d_in(checksum_algorithm_select_in),
        .q_out(alg_sync)
    );
    tcu_sync #(.WIDTH(2)) u_sync_rs (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .d_in(register_select_bits_in),
        .q_out(rs_sync)
    );
    tcu_sync #(.WIDTH(1)) u_sync_rw (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .d_in(read_write_in),
        .q_out(rw_sync)
    );

    // Edges of the synchronised levels
    logic tog_prev;
    logic [1:0] rs_prev;
    logic rw_prev;
    logic mode_primed;
    logic write_evt;
    logic mode_change;
    assign write_evt = tog_sync ^ tog_prev;
    // Algorithm select is not part of the command selection
    assign mode_change = mode_primed
        && ((rs_sync != rs_prev) || (rw_sync != rw_prev));
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            tog_prev <= 1'b0;
        end else begin
            tog_prev <= tog_sync;
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            rs_prev <= 2'h0;
            rw_prev <= 1'b0;
        end else begin
            rs_prev <= rs_sync;
            rw_prev <= rw_sync;
        end
    end
    // No previous mode in the first cycle after reset
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            mode_primed <= 1'b0;
        end else begin
            mode_primed <= 1'b1;
        end
    end

    // Byte is stable: link_byte held since toggle, sampled after sync
    function automatic tcu_pkg::tcu_byte_t crc_step(
        input tcu_pkg::tcu_byte_t c,
        input tcu_pkg::tcu_byte_t d
    );
        tcu_pkg::tcu_byte_t r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ `TCU_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    tcu_pkg::tcu_byte_t csum;
    tcu_pkg::tcu_byte_t next_csum;
    always_comb begin
        next_csum = csum;
        // Clear outranks a write in the same cycle
        if (mode_change) begin
            next_csum = `TCU_CSUM_RESET;
        end else if (write_evt) begin
            if (alg_sync == `TCU_ALG_XOR) begin
                next_csum = csum ^ link_byte;
            end else begin
                next_csum = crc_step(csum, link_byte);
            end
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            csum <= `TCU_CSUM_RESET;
        end else begin
            csum <= next_csum;
        end
    end
    assign checksum_out = csum;

    // Checksum handed back to link domain by toggle handshake
    logic pub_tog;
    logic pub_ready;
    logic ack_sync;
    logic link_ack;
    logic link_take;
    logic pub_sync;
    tcu_pkg::tcu_byte_t pub_val;
    tcu_pkg::tcu_byte_t link_csum;
    // Next value waits until the link side has taken the last
    assign pub_ready = (pub_val != csum) && (pub_tog == ack_sync);
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            pub_tog <= 1'b0;
        end else if (pub_ready) begin
            pub_tog <= ~pub_tog;
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            pub_val <= `TCU_CSUM_RESET;
        end else if (pub_ready) begin
            pub_val <= csum;
        end
    end
    tcu_sync #(.WIDTH(1)) u_sync_ack (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .d_in(link_ack),
        .q_out(ack_sync)
    );
    tcu_sync #(.WIDTH(1)) u_sync_pub (
        .clk_in(link_clk_in),
        .rst_n_in(link_rst_n_in),
        .d_in(pub_tog),
        .q_out(pub_sync)
    );
    assign link_take = pub_sync != link_ack;
    always_ff @(posedge link_clk_in) begin
        if (!link_rst_n_in) begin
            link_ack <= 1'b0;
        end else if (link_take) begin
            link_ack <= pub_sync;
        end
    end
    // Value in pub_val holds still while its toggle is in flight
    always_ff @(posedge link_clk_in) begin
        if (!link_rst_n_in) begin
            link_csum <= `TCU_CSUM_RESET;
        end else if (link_take) begin
            link_csum <= pub_val;
        end
    end

    // Status readback answer, one link cycle after the request
    always_ff @(posedge link_clk_in) begin
        if (!link_rst_n_in) begin
            readback_valid_out <= 1'b0;
        end else begin
            readback_valid_out <= status_read_in;
        end
    end
    always_ff @(posedge link_clk_in) begin
        if (!link_rst_n_in) begin
            readback_data_out <= `TCU_CSUM_RESET;
        end else if (status_read_in) begin
            readback_data_out <= link_csum;
        end
    end
endmodule
`default_nettype wire

// File: inc/tcu_defines.svh
// Constants for the transfer checksum unit
`ifndef TCU_DEFINES_SVH
`define TCU_DEFINES_SVH
`define TCU_CSUM_RESET 8'h00
`define TCU_CRC_POLY 8'h31
`define TCU_ALG_XOR 1'b0
`define TCU_ALG_CRC 1'b1
`endif

// File: inc/tcu_pkg.sv
// Types for the transfer checksum unit
`default_nettype none
package tcu_pkg;
    typedef logic [7:0] tcu_byte_t;
    typedef enum logic [1:0] {
        TCU_IDLE = 2'b01,
        TCU_BUSY = 2'b10
    } tcu_state_t;
endpackage
`default_nettype wire

// File: hw/tcu_sync.sv
// Two-flop synchroniser for a level
`default_nettype none
module tcu_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta <= '0;
            q_out <= '0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule
`default_nettype wire

// File: bench/tcu_host_model.sv
// Host side model: link clock and bus decoder strobes
`default_nettype none
module tcu_host_model (
    // Link strobes
    output logic clk_out,
    output logic wr_out,
    output logic [7:0] byte_out,
    output logic rd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {clk_out, wr_out, byte_out, rd_out} = '0;
        #3.3;
        forever #15 clk_out = ~clk_out;
    end
    task automatic pulse(input logic r, input logic [7:0] b);
        @(posedge clk_out) #1;
        {rd_out, wr_out, byte_out} = {r, !r, b};
        @(posedge clk_out) #1;
        // Released byte lines show no stale value
        {rd_out, wr_out, byte_out} = {2'b00, ~b};
        repeat (6) @(posedge clk_out);
    endtask
endmodule
`default_nettype wire

// File: bench/tcu_top_monitor.sv
// Port assertions for the checksum unit
`default_nettype none
module tcu_top_monitor (
    // Clocks and resets
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic link_clk_in,
    input wire logic link_rst_n_in,
    // Selectors and readback
    input wire logic [1:0] register_select_bits_in,
    input wire logic read_write_in,
    input wire logic status_read_in,
    input wire logic [7:0] readback_data_out,
    input wire logic readback_valid_out,
    input wire logic [7:0] checksum_out
);
    timeunit 1ns;
    timeprecision 1ps;
    a_reset_zero: assert property (@(posedge core_clk_in)
        $rose(rst_n_in) |-> checksum_out == 8'h00) else $error("no zero");
    a_rs_clear: assert property (@(posedge core_clk_in) disable iff
        (!rst_n_in) $changed(register_select_bits_in) |-> ##[1:8]
        checksum_out == 8'h00) else $error("select kept sum");
    a_rw_clear: assert property (@(posedge core_clk_in) disable iff
        (!rst_n_in) $changed(read_write_in) |-> ##[1:8]
        checksum_out == 8'h00) else $error("direction kept sum");
    a_hold_zero: assert property (@(posedge core_clk_in)
        !rst_n_in |=> checksum_out == 8'h00) else $error("reset kept sum");
    a_valid_pulse: assert property (@(posedge link_clk_in) disable iff
        (!link_rst_n_in) readback_valid_out == $past(status_read_in))
        else $error("readback valid off");
    a_data_holds: assert property (@(posedge link_clk_in) disable iff
        (!link_rst_n_in) !readback_valid_out |-> $stable(readback_data_out))
        else $error("readback moved");
endmodule
bind tcu_top tcu_top_monitor tcu_top_monitor_inst (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .link_clk_in(link_clk_in),
    .link_rst_n_in(link_rst_n_in),
    .register_select_bits_in(register_select_bits_in),
    .read_write_in(read_write_in),
    .status_read_in(status_read_in),
    .readback_data_out(readback_data_out),
    .readback_valid_out(readback_valid_out),
    .checksum_out(checksum_out)
);
`default_nettype wire

// File: bench/transfer_checksum_unit_tb.sv
// Bench for the transfer checksum unit
`default_nettype none
module transfer_checksum_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in = 0, rst_n_in = 0, alg = 0, rw = 0, wr, rd, lck, v;
    logic [1:0] rs = 0;
    logic [7:0] d, q, cs, sum = 0, eq[$];
    logic [31:0] lf = 32'h4d3fbfd1;
    int n_fail = 0, n_tests = 0;
    always #4 core_clk_in = ~core_clk_in;
    tcu_host_model tcu_host_model_inst (.clk_out(lck), .wr_out(wr),
        .byte_out(d), .rd_out(rd));
    tcu_top tcu_top_inst (.core_clk_in, .rst_n_in, .link_clk_in(lck),
        .link_rst_n_in(rst_n_in), .data_write_in(wr), .data_byte_in(d),
        .checksum_algorithm_select_in(alg), .register_select_bits_in(rs),
        .read_write_in(rw), .status_read_in(rd), .readback_data_out(q),
        .readback_valid_out(v), .checksum_out(cs));
    function automatic logic [7:0] step(logic [7:0] c, b, logic a);
        c = c ^ b;
        for (int i = 0; i < 8 && a; i++)
            c = {c[6:0], 1'b0} ^ (c[7] ? 8'h31 : 8'h00);
        return c;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic put(input logic [7:0] b);
        tcu_host_model_inst.pulse(1'b0, b);
        sum = step(sum, b, alg);
    endtask
    task automatic ask;
        eq.push_back(sum);
        tcu_host_model_inst.pulse(1'b1, 8'h00);
    endtask
    task automatic sel(input logic [3:0] s);
        @(posedge lck) #1;
        if ({rs, rw} !== s[2:0])
            sum = 8'h00;
        {alg, rs, rw} = s;
        repeat (6) @(posedge lck);
    endtask
    task automatic report_and_stop;
        if (eq.size() != 0)
            n_fail++;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge lck) begin
        if (v === 1'b1) begin
            n_tests++;
            if (eq.size() == 0 || q !== eq.pop_front()) begin
                $display("unexpected %0t readback %h", $time, q);
                n_fail++;
            end
        end
    end
    initial begin
        repeat (6) @(posedge lck);
        #1 rst_n_in = 1;
        repeat (4) @(posedge lck);
        ask;
        for (int m = 0; m < 16; m++) begin
            sel(m[3:0]);
            repeat (3) begin
                lf = lfsr(lf);
                put(lf[7:0]);
            end
            ask;
            sel(m[3:0]);
            put(8'hff);
            ask;
        end
        sel(4'h7);
        put(8'h5a);
        ask;
        report_and_stop;
    end
    initial begin
        #100us;
        n_fail++;
        report_and_stop;
    end
endmodule
`default_nettype wire
